// [rtl/mis_defines.svh]
// Register map, field positions, reset values and timing counts
`ifndef MIS_DEFINES_SVH
`define MIS_DEFINES_SVH
// Register indices; byte address is four times the index
`define MIS_IDX_CTRL     6'h35
`define MIS_IDX_IEN      6'h36
`define MIS_IDX_IFLG     6'h37
`define MIS_IDX_STAT     6'h38
`define MIS_IDX_SP       6'h39
// Reset values
`define MIS_CTRL_RST     8'h00
`define MIS_IEN_RST      2'h0
`define MIS_SP_RST       16'h025f
// Control register fields
`define MIS_B_MEM_EN     7
`define MIS_B_WAIT       6
`define MIS_B_SLEEP_EN   5
`define MIS_B_SLEEP_MODE 4
`define MIS_F_SENSE1     3:2
`define MIS_F_SENSE0     1:0
// Enable register fields
`define MIS_B_GIE        7
`define MIS_F_IEN        1:0
// Sense encodings
`define MIS_SENSE_LOW    2'h0
`define MIS_SENSE_FALL   2'h2
`define MIS_SENSE_RISE   2'h3
// Sequencing counts, loaded as cycles minus one, and the stack pointer step in bytes
`define MIS_ENTRY_LOAD   3'h3
`define MIS_RET_LOAD     3'h3
`define MIS_STK_LOAD     3'h5
`define MIS_JUMP_LOAD    3'h1
`define MIS_PC_BYTES     16'h0002
// Data space decode
`define MIS_REGIO_END    16'h0060
`define MIS_INT_END      16'h0260
`define MIS_EXT_EXTRA    2'h1
`define MIS_REG_REGIO    2'h0
`define MIS_REG_INT      2'h1
`define MIS_REG_EXT      2'h2
// Bus responses
`define MIS_RESP_OK      2'h0
`define MIS_RESP_ERR     2'h2
`endif

// [rtl/mis_pkg.sv]
// Types for the interrupt, sleep and memory control block
package mis_pkg;
   typedef enum logic [2:0] {
      MIS_RUN   = 3'h0,
      MIS_ENTRY = 3'h1,
      MIS_JUMP  = 3'h2,
      MIS_RET   = 3'h3,
      MIS_POST  = 3'h4,
      MIS_SLEEP = 3'h5
   } mis_fsm_t;

   typedef struct packed {
      mis_fsm_t    st;
      logic [2:0]  cnt;
      logic        xstk;
      logic [1:0]  sy1;
      logic [1:0]  sy2;
      logic [1:0]  sy3;
      logic [1:0]  flag;
      logic [1:0]  pend;
      logic [7:0]  ctrl;
      logic [1:0]  ien;
      logic        gie;
      logic [15:0] sp;
      logic        vec_id;
      logic        vec_pulse;
      logic        handler_pulse;
      logic        push;
      logic        pop;
      logic        hold;
      logic        sleeping;
      logic        osc_stop;
      logic        pin_ovr;
      logic        ext_rd_n;
      logic        ext_wr_n;
      logic        stall;
      logic [1:0]  mcnt;
      logic        mwe;
      logic [15:0] ext_addr;
      logic [1:0]  region;
      logic        awready;
      logic        wready;
      logic        aw_have;
      logic        w_have;
      logic [5:0]  aw_idx;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } mis_state_t;
endpackage : mis_pkg

// [rtl/mis_ctrl.sv]
// Interrupt sensing, entry/return sequencing, sleep and data memory control
`timescale 1ns/1ps
`include "mis_defines.svh"
module mis_ctrl
   import mis_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // External interrupt pins
   input  wire logic        ext_irq_pin_zero,
   input  wire logic        ext_irq_pin_one,
   // CPU core
   input  wire logic        cpu_instr_end,
   input  wire logic        cpu_reti,
   input  wire logic        cpu_sleep,
   input  wire logic        cpu_mem_req,
   input  wire logic        cpu_mem_we,
   input  wire logic [15:0] cpu_mem_addr,
   output logic             cpu_hold,
   output logic             pc_push,
   output logic             pc_pop,
   output logic             vec_start,
   output logic             vec_id,
   output logic             handler_start,
   output logic [15:0]      stack_ptr,
   output logic [1:0]       irq_pending,
   // Sleep
   output logic             sleeping,
   output logic             osc_stop,
   // External data memory
   output logic             mem_pins_override,
   output logic             mem_stall,
   output logic             ext_rd_n,
   output logic             ext_wr_n,
   output logic [15:0]      ext_addr,
   output logic [1:0]       mem_region
);
   mis_state_t r;
   mis_state_t n;
   logic [1:0] lvl;
   logic [1:0] edg;
   logic [1:0] edge_mode;
   logic [1:0] pend_c;

   // Pins are read after synchronising, whatever drives them
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_sense
         logic [1:0] mode;
         assign mode = (gi == 0) ? r.ctrl[`MIS_F_SENSE0]
                                 : r.ctrl[`MIS_F_SENSE1];
         assign lvl[gi] = (mode == `MIS_SENSE_LOW) && !r.sy2[gi];
         assign edg[gi] = ((mode == `MIS_SENSE_FALL) && r.sy3[gi]
                           && !r.sy2[gi])
                       || ((mode == `MIS_SENSE_RISE) && !r.sy3[gi]
                           && r.sy2[gi]);
         assign edge_mode[gi] = mode[1];
      end
   endgenerate

   // Level request is never stored; edge flags only count in edge modes
   assign pend_c = r.ien & (lvl | (r.flag & edge_mode));

   always_comb
   begin
      logic        do_entry;
      logic        ext_hit;
      logic [1:0]  clr;
      logic [31:0] rd;
      logic        rd_ok;
      logic        wr_ok;
      logic        wake;
      n        = r;
      do_entry = 1'b0;
      ext_hit  = 1'b0;
      clr      = 2'h0;
      rd       = 32'h0000_0000;
      rd_ok    = 1'b1;
      wr_ok    = 1'b1;
      wake     = 1'b0;
      n.sy1 = {ext_irq_pin_one, ext_irq_pin_zero};
      n.sy2 = r.sy1;
      n.sy3 = r.sy2;
      n.vec_pulse     = 1'b0;
      n.handler_pulse = 1'b0;
      n.push          = 1'b0;
      n.pop           = 1'b0;

      // Write channel
      if (s_axi_awvalid && r.awready)
      begin
         n.aw_have = 1'b1;
         n.awready = 1'b0;
         n.aw_idx  = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && r.wready)
      begin
         n.w_have = 1'b1;
         n.wready = 1'b0;
         n.wdata  = s_axi_wdata;
         n.wstrb  = s_axi_wstrb;
      end
      if (r.aw_have && r.w_have && !r.bvalid)
      begin
         n.aw_have = 1'b0;
         n.w_have  = 1'b0;
         n.bvalid  = 1'b1;
         unique case (r.aw_idx)
            `MIS_IDX_CTRL:
               if (r.wstrb[0])
                  n.ctrl = r.wdata[7:0];
            `MIS_IDX_IEN:
               if (r.wstrb[0])
               begin
                  n.ien = r.wdata[`MIS_F_IEN];
                  n.gie = r.wdata[`MIS_B_GIE];
               end
            `MIS_IDX_IFLG:
               if (r.wstrb[0])
                  clr = r.wdata[1:0];
            `MIS_IDX_SP:
            begin
               if (r.wstrb[0])
                  n.sp[7:0] = r.wdata[7:0];
               if (r.wstrb[1])
                  n.sp[15:8] = r.wdata[15:8];
            end
            `MIS_IDX_STAT: ;
            default:
               wr_ok = 1'b0;
         endcase
         n.bresp = wr_ok ? `MIS_RESP_OK : `MIS_RESP_ERR;
      end
      if (r.bvalid && s_axi_bready)
      begin
         n.bvalid  = 1'b0;
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end

      // Read channel, answered one cycle after the address is taken
      unique case (s_axi_araddr[7:2])
         `MIS_IDX_CTRL: rd[7:0]  = r.ctrl;
         `MIS_IDX_IEN:  rd[7:0]  = {r.gie, 5'h00, r.ien};
         `MIS_IDX_IFLG: rd[7:0]  = {4'h0, lvl, r.flag};
         `MIS_IDX_STAT: rd[7:0]  = {r.st, r.sleeping, r.osc_stop,
                                    r.xstk, r.pend};
         `MIS_IDX_SP:   rd[15:0] = r.sp;
         default:       rd_ok    = 1'b0;
      endcase
      if (s_axi_arvalid && r.arready)
      begin
         n.arready = 1'b0;
         n.rvalid  = 1'b1;
         n.rdata   = rd;
         n.rresp   = rd_ok ? `MIS_RESP_OK : `MIS_RESP_ERR;
      end
      if (r.rvalid && s_axi_rready)
      begin
         n.rvalid  = 1'b0;
         n.arready = 1'b1;
      end

      // Sequencer; the core status register is left to software
      unique case (r.st)
         MIS_RUN:
            if (cpu_instr_end && r.gie && |pend_c)
               do_entry = 1'b1;
            else if (cpu_reti)
            begin
               n.st   = MIS_RET;
               n.pop  = 1'b1;
               n.xstk = r.ctrl[`MIS_B_MEM_EN] && (r.sp >= `MIS_INT_END);
               n.cnt  = n.xstk ? `MIS_STK_LOAD : `MIS_RET_LOAD;
            end
            else if (cpu_instr_end && cpu_sleep
                     && r.ctrl[`MIS_B_SLEEP_EN])
            begin
               n.st       = MIS_SLEEP;
               n.sleeping = 1'b1;
               n.osc_stop = r.ctrl[`MIS_B_SLEEP_MODE];
            end
         MIS_ENTRY:
            if (r.cnt == 3'h0)
            begin
               n.st        = MIS_JUMP;
               n.cnt       = `MIS_JUMP_LOAD;
               n.sp        = r.sp - `MIS_PC_BYTES;
               n.vec_pulse = 1'b1;
            end
            else
               n.cnt = r.cnt - 3'h1;
         MIS_JUMP:
            if (r.cnt == 3'h0)
            begin
               n.st            = MIS_RUN;
               n.handler_pulse = 1'b1;
            end
            else
               n.cnt = r.cnt - 3'h1;
         MIS_RET:
            if (r.cnt == 3'h0)
            begin
               n.st  = MIS_POST;
               n.sp  = r.sp + `MIS_PC_BYTES;
               n.gie = 1'b1;
            end
            else
               n.cnt = r.cnt - 3'h1;
         MIS_POST:
            if (cpu_instr_end)
               n.st = MIS_RUN;
         MIS_SLEEP:
         begin
            // Power-down has no clock for edge detection
            wake = r.osc_stop ? |(r.ien & lvl) : |pend_c;
            if (wake)
            begin
               n.sleeping = 1'b0;
               n.osc_stop = 1'b0;
               if (r.gie)
                  do_entry = 1'b1;
               else
                  n.st = MIS_RUN;
            end
         end
         default:
            n.st = MIS_RUN;
      endcase

      if (do_entry)
      begin
         n.st     = MIS_ENTRY;
         n.push   = 1'b1;
         n.gie    = 1'b0;
         n.vec_id = !pend_c[0];
         n.xstk   = r.ctrl[`MIS_B_MEM_EN] && (r.sp >= `MIS_INT_END);
         n.cnt    = n.xstk ? `MIS_STK_LOAD : `MIS_ENTRY_LOAD;
         clr[n.vec_id] = clr[n.vec_id] | edge_mode[n.vec_id];
      end
      // A new edge wins over any clear in the same cycle
      n.flag = (r.flag & ~clr) | (edg & edge_mode);
      n.pend = pend_c;
      n.hold = (n.st == MIS_ENTRY) || (n.st == MIS_JUMP)
            || (n.st == MIS_RET) || (n.st == MIS_SLEEP);

      // Data space accesses
      n.pin_ovr = r.ctrl[`MIS_B_MEM_EN];
      if (r.mcnt != 2'h0)
         n.mcnt = r.mcnt - 2'h1;
      else if (cpu_mem_req)
      begin
         n.ext_addr = cpu_mem_addr;
         n.mwe      = cpu_mem_we;
         if (cpu_mem_addr < `MIS_REGIO_END)
            n.region = `MIS_REG_REGIO;
         else if (cpu_mem_addr < `MIS_INT_END)
            n.region = `MIS_REG_INT;
         else
         begin
            n.region = `MIS_REG_EXT;
            ext_hit  = r.ctrl[`MIS_B_MEM_EN];
         end
         if (ext_hit)
            n.mcnt = `MIS_EXT_EXTRA
                   + {1'b0, r.ctrl[`MIS_B_WAIT]};
      end
      n.stall    = n.mcnt != 2'h0;
      n.ext_rd_n = !(n.stall && !n.mwe);
      n.ext_wr_n = !(n.stall && n.mwe);
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r          <= '0;
         r.st       <= MIS_RUN;
         r.ctrl     <= `MIS_CTRL_RST;
         r.ien      <= `MIS_IEN_RST;
         r.sp       <= `MIS_SP_RST;
         r.sy1      <= 2'h3;
         r.sy2      <= 2'h3;
         r.sy3      <= 2'h3;
         r.ext_rd_n <= 1'b1;
         r.ext_wr_n <= 1'b1;
         r.awready  <= 1'b1;
         r.wready   <= 1'b1;
         r.arready  <= 1'b1;
      end
      else
         r <= n;
   end

   assign s_axi_awready     = r.awready;
   assign s_axi_wready      = r.wready;
   assign s_axi_bvalid      = r.bvalid;
   assign s_axi_bresp       = r.bresp;
   assign s_axi_arready     = r.arready;
   assign s_axi_rvalid      = r.rvalid;
   assign s_axi_rdata       = r.rdata;
   assign s_axi_rresp       = r.rresp;
   assign cpu_hold          = r.hold;
   assign pc_push           = r.push;
   assign pc_pop            = r.pop;
   assign vec_start         = r.vec_pulse;
   assign vec_id            = r.vec_id;
   assign handler_start     = r.handler_pulse;
   assign stack_ptr         = r.sp;
   assign irq_pending       = r.pend;
   assign sleeping          = r.sleeping;
   assign osc_stop          = r.osc_stop;
   assign mem_pins_override = r.pin_ovr;
   assign mem_stall         = r.stall;
   assign ext_rd_n          = r.ext_rd_n;
   assign ext_wr_n          = r.ext_wr_n;
   assign ext_addr          = r.ext_addr;
   assign mem_region        = r.region;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_entry4;
      (r.st == MIS_ENTRY) [*4] ##1 (r.st == MIS_JUMP && r.vec_pulse);
   endsequence
   sequence s_ret4;
      (r.st == MIS_RET) [*4] ##1 (r.st == MIS_POST && r.gie);
   endsequence

   property p_level_req;
      (r.ctrl[`MIS_F_SENSE0] == `MIS_SENSE_LOW) && r.ien[0] && !r.sy2[0]
         |=> r.pend[0];
   endproperty
   a_level_req: assert property (p_level_req)
      else $error("level request not raised");

   property p_level_drop;
      (r.ctrl[`MIS_F_SENSE1] == `MIS_SENSE_LOW) && r.sy2[1] |=> !r.pend[1];
   endproperty
   a_level_drop: assert property (p_level_drop)
      else $error("level request held after pin high");

   property p_entry;
      $rose(r.st == MIS_ENTRY) && !r.xstk |-> s_entry4;
   endproperty
   a_entry: assert property (p_entry)
      else $error("entry not four cycles");

   property p_entry_sp;
      r.st == MIS_ENTRY && r.cnt == 3'h0 |=> r.sp == $past(r.sp) - 16'h0002;
   endproperty
   a_entry_sp: assert property (p_entry_sp)
      else $error("stack pointer not lowered by two");

   property p_jump;
      r.vec_pulse |-> ##2 r.handler_pulse;
   endproperty
   a_jump: assert property (p_jump)
      else $error("vector jump not two cycles");

   property p_ret;
      $rose(r.st == MIS_RET) && !r.xstk |-> s_ret4;
   endproperty
   a_ret: assert property (p_ret)
      else $error("return not four cycles");

   property p_post;
      r.st == MIS_POST && !cpu_instr_end |=> r.st != MIS_ENTRY;
   endproperty
   a_post: assert property (p_post)
      else $error("interrupt taken before one instruction");

   property p_xstk;
      $rose(r.st == MIS_ENTRY) && r.xstk |-> (r.st == MIS_ENTRY) [*6];
   endproperty
   a_xstk: assert property (p_xstk)
      else $error("external stack entry not six cycles");

   property p_wait;
      r.mcnt == 2'h0 && cpu_mem_req && cpu_mem_addr >= `MIS_INT_END
      && r.ctrl[`MIS_B_MEM_EN] && r.ctrl[`MIS_B_WAIT]
         |=> r.stall [*2] ##1 !r.stall;
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait state access length wrong");

   property p_internal;
      r.mcnt == 2'h0 && cpu_mem_req && cpu_mem_addr < `MIS_INT_END
         |=> r.ext_rd_n && r.ext_wr_n && !r.stall;
   endproperty
   a_internal: assert property (p_internal)
      else $error("strobe active on internal access");

   property p_no_sleep;
      r.st == MIS_RUN && !r.ctrl[`MIS_B_SLEEP_EN] |=> !r.sleeping;
   endproperty
   a_no_sleep: assert property (p_no_sleep)
      else $error("slept without sleep enable");

   property p_pd_wake;
      r.st == MIS_SLEEP && r.osc_stop && !(|(r.ien & lvl)) |=> r.sleeping;
   endproperty
   a_pd_wake: assert property (p_pd_wake)
      else $error("power-down woke without level request");
endmodule : mis_ctrl

// [testbench/mis_irq_src.sv]
// External interrupt source model driving the two interrupt pins
`timescale 1ns/1ps
module mis_irq_src #(
   parameter int HOLD_MIN = 4
)(
   // Clock
   input  wire logic       sys_clk,
   // Commands from the bench, one bit a pin
   input  wire logic [1:0] want_low,
   // Pins, idle high by pull-up
   output logic [1:0]      pins
);
   logic [3:0] cnt [2];

   initial
   begin
      pins = 2'b11;
      cnt[0] = 4'h0;
      cnt[1] = 4'h0;
   end

   // A low level is kept past the wake-up delay, or power-down wake fails
   always @(posedge sys_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (want_low[i])
         begin
            pins[i] <= 1'b0;
            if (cnt[i] != 4'hf)
               cnt[i] <= cnt[i] + 4'h1;
         end
         else if (32'(cnt[i]) >= HOLD_MIN)
         begin
            pins[i] <= 1'b1;
            cnt[i]  <= 4'h0;
         end
         else if (!pins[i])
            cnt[i] <= cnt[i] + 4'h1;
      end
   end
endmodule : mis_irq_src

// [testbench/tb_mis_ctrl.sv]
// Self-checking bench for the interrupt, sleep and memory control block
`timescale 1ns/1ps
`include "mis_defines.svh"
module tb_mis_ctrl;
   localparam logic [7:0] A_CTRL = {`MIS_IDX_CTRL, 2'b00};
   localparam logic [7:0] A_IEN  = {`MIS_IDX_IEN, 2'b00};
   localparam logic [7:0] A_FLG  = {`MIS_IDX_IFLG, 2'b00};
   localparam logic [7:0] A_SP   = {`MIS_IDX_SP, 2'b00};
   logic sys_clk = 1'b0, resetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, pins, irq_pending, mem_region;
   logic [31:0] rdata, d;
   logic [1:0]  want_low = 2'b00, r;
   logic instr_end = 1'b0, reti = 1'b0, slp = 1'b0;
   logic mreq = 1'b0, mwe = 1'b0;
   logic [15:0] maddr = 16'h0, stack_ptr, ext_addr;
   logic cpu_hold, pc_push, pc_pop, vec_start, vec_id, handler_start;
   logic sleeping, osc_stop, mem_pins_override, mem_stall;
   logic ext_rd_n, ext_wr_n;
   int   err_total = 0, compares = 0, pushes = 0, n;

   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (pc_push === 1'b1)
         pushes++;

   mis_irq_src #(.HOLD_MIN(4)) mis_irq_src_i (.sys_clk(sys_clk),
      .want_low(want_low), .pins(pins));

   mis_ctrl mis_ctrl_i (.sys_clk(sys_clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_irq_pin_zero(pins[0]), .ext_irq_pin_one(pins[1]),
      .cpu_instr_end(instr_end), .cpu_reti(reti), .cpu_sleep(slp),
      .cpu_mem_req(mreq), .cpu_mem_we(mwe), .cpu_mem_addr(maddr),
      .cpu_hold(cpu_hold), .pc_push(pc_push), .pc_pop(pc_pop),
      .vec_start(vec_start), .vec_id(vec_id),
      .handler_start(handler_start), .stack_ptr(stack_ptr),
      .irq_pending(irq_pending), .sleeping(sleeping), .osc_stop(osc_stop),
      .mem_pins_override(mem_pins_override), .mem_stall(mem_stall),
      .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_addr(ext_addr),
      .mem_region(mem_region));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task axi_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle count is assumed; only the watchdog ends a lost answer
      do
      begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task axi_rd(input logic [7:0] a);
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task pulse_end(input logic sl);
      @(posedge sys_clk);
      instr_end <= 1'b1; slp <= sl;
      @(posedge sys_clk);
      instr_end <= 1'b0; slp <= 1'b0;
   endtask : pulse_end

   task pulse_reti;
      @(posedge sys_clk);
      reti <= 1'b1;
      @(posedge sys_clk);
      reti <= 1'b0;
   endtask : pulse_reti

   task t_regs;
      axi_rd(A_CTRL);
      chk(d, 32'(`MIS_CTRL_RST));
      axi_rd(A_SP);
      chk(d, 32'(`MIS_SP_RST));
      axi_wr(A_CTRL, 32'ha5);
      axi_rd(A_CTRL);
      chk(d, 32'ha5);
      axi_wr(8'h00, 32'h1);
      chk(r, `MIS_RESP_ERR);
      axi_rd(8'h00);
      chk(r, `MIS_RESP_ERR);
      axi_wr(A_CTRL, 32'h0);
   endtask : t_regs

   task t_level;
      axi_wr(A_IEN, 32'h02);
      want_low <= 2'b10;
      repeat (8) @(posedge sys_clk);
      chk(irq_pending[1], 1'b1);
      want_low <= 2'b00;
      repeat (12) @(posedge sys_clk);
      chk(irq_pending[1], 1'b0);
   endtask : t_level

   task t_edge;
      axi_wr(A_CTRL, 32'h0c);
      want_low <= 2'b10;
      repeat (8) @(posedge sys_clk);
      axi_rd(A_FLG);
      chk(d & 32'h3, 32'h0);
      want_low <= 2'b00;
      repeat (10) @(posedge sys_clk);
      axi_rd(A_FLG);
      chk(d & 32'h3, 32'h2);
      axi_wr(A_FLG, 32'h2);
      repeat (4) @(posedge sys_clk);
      axi_rd(A_FLG);
      chk(d & 32'h3, 32'h0);
   endtask : t_edge

   task t_entry;
      axi_wr(A_CTRL, 32'h02);
      axi_wr(A_IEN, 32'h81);
      want_low <= 2'b01;
      repeat (6) @(posedge sys_clk);
      pulse_end(1'b0);
      for (n = 0; n < 20 && pc_push !== 1'b1; n++) @(posedge sys_clk);
      chk(cpu_hold, 1'b1);
      for (n = 0; n < 20 && vec_start !== 1'b1; n++) @(posedge sys_clk);
      chk(n, 4);
      chk(vec_id, 1'b0);
      for (n = 0; n < 20 && handler_start !== 1'b1; n++) @(posedge sys_clk);
      chk(n, 2);
      chk(stack_ptr, 16'h025d);
      want_low <= 2'b00;
   endtask : t_entry

   task t_ret;
      int p0;
      axi_wr(A_CTRL, 32'h00);
      want_low <= 2'b01;
      pulse_reti;
      // Pop pulses one cycle after the return is taken
      @(posedge sys_clk);
      chk(pc_pop, 1'b1);
      for (n = 0; n < 30 && cpu_hold !== 1'b0; n++) @(posedge sys_clk);
      chk(n, 4);
      chk(stack_ptr, 16'h025f);
      p0 = pushes;
      repeat (5) @(posedge sys_clk);
      chk(pushes, p0);
      pulse_end(1'b0);
      pulse_end(1'b0);
      for (n = 0; n < 20 && pc_push !== 1'b1; n++) @(posedge sys_clk);
      chk(n < 20, 1'b1);
      want_low <= 2'b00;
      for (n = 0; n < 20 && handler_start !== 1'b1; n++) @(posedge sys_clk);
      pulse_reti;
      @(posedge sys_clk);
      for (n = 0; n < 30 && cpu_hold !== 1'b0; n++) @(posedge sys_clk);
      axi_rd(A_IEN);
      chk(d[7], 1'b1);
   endtask : t_ret

   task mem_acc(input logic [15:0] a, input logic we, input logic [1:0] rg,
                input int stalls);
      int s, lo;
      @(posedge sys_clk);
      mreq <= 1'b1; maddr <= a; mwe <= we;
      @(posedge sys_clk);
      mreq <= 1'b0;
      s = 0;
      lo = 0;
      repeat (6)
      begin
         @(posedge sys_clk);
         if (mem_stall === 1'b1) s++;
         if (ext_rd_n !== 1'b1 || ext_wr_n !== 1'b1) lo++;
      end
      chk(s, stalls);
      chk(lo != 0, stalls != 0);
      chk(mem_region, rg);
      chk(ext_addr, a);
   endtask : mem_acc

   task t_mem;
      axi_wr(A_CTRL, 32'hc0);
      // Pin override follows the control bit one cycle after the write
      @(posedge sys_clk);
      chk(mem_pins_override, 1'b1);
      mem_acc(16'h0300, 1'b0, `MIS_REG_EXT, 2);
      axi_wr(A_CTRL, 32'h80);
      mem_acc(16'h0260, 1'b1, `MIS_REG_EXT, 1);
      mem_acc(16'h025f, 1'b0, `MIS_REG_INT, 0);
      mem_acc(16'h005f, 1'b1, `MIS_REG_REGIO, 0);
      mem_acc(16'h0060, 1'b0, `MIS_REG_INT, 0);
      axi_wr(A_CTRL, 32'h00);
      @(posedge sys_clk);
      chk(mem_pins_override, 1'b0);
   endtask : t_mem

   task t_xstk;
      axi_wr(A_CTRL, 32'h80);
      axi_wr(A_SP, 32'h0300);
      axi_wr(A_IEN, 32'h81);
      want_low <= 2'b01;
      repeat (6) @(posedge sys_clk);
      pulse_end(1'b0);
      pulse_end(1'b0);
      for (n = 0; n < 20 && pc_push !== 1'b1; n++) @(posedge sys_clk);
      for (n = 0; n < 20 && vec_start !== 1'b1; n++) @(posedge sys_clk);
      chk(n, 6);
      chk(stack_ptr, 16'h02fe);
      want_low <= 2'b00;
      for (n = 0; n < 20 && handler_start !== 1'b1; n++) @(posedge sys_clk);
      pulse_reti;
      @(posedge sys_clk);
      for (n = 0; n < 30 && cpu_hold !== 1'b0; n++) @(posedge sys_clk);
      chk(n, 6);
      chk(stack_ptr, 16'h0300);
      axi_wr(A_CTRL, 32'h00);
   endtask : t_xstk

   task t_sleep;
      logic [7:0] modes [2];
      modes[0] = 8'h30;
      modes[1] = 8'h22;
      axi_wr(A_IEN, 32'h01);
      pulse_end(1'b1);
      // First boundary only leaves the post-return state
      pulse_end(1'b1);
      @(posedge sys_clk);
      chk(sleeping, 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         axi_wr(A_CTRL, 32'(modes[i]));
         pulse_end(1'b1);
         @(posedge sys_clk);
         chk(sleeping, 1'b1);
         chk(cpu_hold, 1'b1);
         chk(osc_stop, modes[i][4]);
         want_low <= 2'b01;
         for (n = 0; n < 20 && sleeping !== 1'b0; n++) @(posedge sys_clk);
         chk(n < 20, 1'b1);
         want_low <= 2'b00;
         repeat (10) @(posedge sys_clk);
      end
      axi_wr(A_CTRL, 32'h20);
      pulse_end(1'b1);
      @(posedge sys_clk);
      chk(sleeping, 1'b1);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk(sleeping, 1'b0);
      axi_rd(A_CTRL);
      chk(d, 32'(`MIS_CTRL_RST));
   endtask : t_sleep

   task final_report;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   // Whole run is a few hundred cycles; this only catches a hang
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      final_report;
   end

   initial
   begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_regs;
      t_level;
      t_edge;
      t_entry;
      t_ret;
      t_mem;
      t_xstk;
      t_sleep;
      final_report;
   end
endmodule : tb_mis_ctrl
